/* pkg/cbc_pkg.sv */
// Package of constants and types for the cache block coherence engine
`default_nettype none
package cbc_pkg;
  localparam int ADDR_W = 32;
  localparam int WC_W = 16;
  localparam int WORD_BYTES = 4;
  localparam int LINE_WORDS = 16;
  localparam logic [WC_W-1:0] WC_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] BASE_RESET = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] LINE_BYTES = 32'h0000_0040;

  // Operation select: bit 2 chooses the level-2 cache, bits 1:0 the action
  localparam int OP_W = 3;
  localparam logic [2:0] OP_L1_WB = 3'h1;
  localparam logic [2:0] OP_L1_INV = 3'h2;
  localparam logic [2:0] OP_L1_WBINV = 3'h3;
  localparam logic [2:0] OP_L2_WB = 3'h5;
  localparam logic [2:0] OP_L2_INV = 3'h6;
  localparam logic [2:0] OP_L2_WBINV = 3'h7;
  localparam int OP_LEVEL_BIT = 2;
  localparam int OP_WB_BIT = 0;
  localparam int OP_INV_BIT = 1;

  typedef enum logic [3:0] {
    CBC_IDLE  = 4'h1,
    CBC_ISSUE = 4'h2,
    CBC_WAIT  = 4'h4,
    CBC_DONE  = 4'h8
  } cbc_state_t;

  typedef struct packed {
    cbc_state_t        state;
    logic [OP_W-1:0]   op;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] line_addr;
    logic [WC_W-1:0]   count;
    logic              req_valid;
    logic              req_l2;
    logic              req_wb;
    logic              req_inv;
    logic [ADDR_W-1:0] req_addr;
    logic              busy;
    logic              fence_stall;
    logic              set_guard;
  } cbc_regs_t;

  // Words left after one line is processed, clamped at zero
  function automatic logic [WC_W-1:0] cbc_words_left(input logic [WC_W-1:0] wc);
    logic [WC_W-1:0] lw;
    lw = WC_W'(LINE_WORDS);
    cbc_words_left = (wc > lw) ? wc - lw : '0;
  endfunction : cbc_words_left
endpackage : cbc_pkg
`default_nettype wire

/* hdl/cbc_engine.sv */
// Block coherence engine: range writeback and invalidate on level-1 data and level-2 caches
`default_nettype none
// What this block does
// R1 - Six range operations: writeback, invalidate, both; for level-1 data and level-2 caches.
// R2 - Host loads the range start into the chosen operation's base register first.
// R3 - Host then writes the range length in words to that operation's count register.
// R4 - Count reads nonzero while an operation runs and zero once it finishes.
// R5 - A memory fence stalls the core until outstanding work, this engine included, completes.
// R6 - Host keeps memory idle during an operation and waits for completion first.
// R7 - Host wraps each operation: interrupts off, address, count, wait, 16 no-ops, restore.
// R8 - Level-2 set stays correct over miss, coherence op, allocate, allocate back-to-back.
// R9 - Nonzero count write starts the operation at the base; count drops per line.
module cbc_engine
  import cbc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              base_wr,
  input  wire logic [OP_W-1:0]   base_op,
  input  wire logic [ADDR_W-1:0] base_data,
  input  wire logic              range_word_count_reg_wr,
  input  wire logic [OP_W-1:0]   range_word_count_reg_op,
  input  wire logic [WC_W-1:0]   range_word_count_reg_data,
  input  wire logic              memory_fence_instr,
  input  wire logic              mem_pending,
  input  wire logic              cache_ack,
  output logic [WC_W-1:0]        range_word_count_reg,
  output logic                   busy,
  output logic                   fence_stall,
  output logic                   req_valid,
  output logic                   req_l2,
  output logic                   req_wb,
  output logic                   req_inv,
  output logic [ADDR_W-1:0]      req_addr,
  output logic                   set_guard
);

  // Engine state and the value it takes at the next edge
  cbc_regs_t r;
  cbc_regs_t next_r;

  // Everything cleared except op, which loads OP_L1_WB, and state, which loads CBC_IDLE: the engine wakes idle with a zero count
  localparam cbc_regs_t REGS_RESET = '{
    state:       CBC_IDLE,
    op:          OP_L1_WB,
    base:        BASE_RESET,
    line_addr:   BASE_RESET,
    count:       WC_RESET,
    req_valid:   1'b0,
    req_l2:      1'b0,
    req_wb:      1'b0,
    req_inv:     1'b0,
    req_addr:    BASE_RESET,
    busy:        1'b0,
    fence_stall: 1'b0,
    set_guard:   1'b0
  };

  function automatic logic op_legal(input logic [OP_W-1:0] op);
    op_legal = op[OP_WB_BIT] | op[OP_INV_BIT];
  endfunction : op_legal

  function automatic logic op_is_l2(input logic [OP_W-1:0] op);
    op_is_l2 = op[OP_LEVEL_BIT];
  endfunction : op_is_l2

  function automatic logic op_does_wb(input logic [OP_W-1:0] op);
    op_does_wb = op[OP_WB_BIT];
  endfunction : op_does_wb

  function automatic logic op_does_inv(input logic [OP_W-1:0] op);
    op_does_inv = op[OP_INV_BIT];
  endfunction : op_does_inv

  // Start of the line that holds a byte address
  function automatic logic [ADDR_W-1:0] line_align(input logic [ADDR_W-1:0] addr);
    line_align = addr & ~(LINE_BYTES - 32'h0000_0001);
  endfunction : line_align

  // Base writes are taken only while no operation owns the register
  function automatic logic base_take(input logic wr, input cbc_state_t st);
    base_take = wr && (st == CBC_IDLE);
  endfunction : base_take

  // A count write starts work only if nonzero, legal and matching the base op
  function automatic logic count_start_ok(
    input logic            wr,
    input logic [OP_W-1:0] op,
    input logic [WC_W-1:0] words,
    input logic [OP_W-1:0] base_op_q
  );
    logic words_nonzero;
    logic op_match;
    words_nonzero = (words != WC_RESET);
    op_match = (op == base_op_q);
    count_start_ok = wr & words_nonzero & op_legal(op) & op_match;
  endfunction : count_start_ok

  // True when the acknowledged line was the last one of the range
  function automatic logic last_line(input logic [WC_W-1:0] wc);
    last_line = (cbc_words_left(wc) == WC_RESET);
  endfunction : last_line

  always_comb begin
    next_r = r;
    next_r.req_valid = 1'b0;

    // One base register, tagged with the op it was loaded for
    if (base_take(base_wr, r.state)) begin
      next_r.base = base_data; // R2
      next_r.op = base_op;
    end

    case (r.state)
      CBC_IDLE: begin
        if (count_start_ok(range_word_count_reg_wr, range_word_count_reg_op,
                           range_word_count_reg_data, r.op)) begin
          next_r.count = range_word_count_reg_data; // R3
          next_r.line_addr = line_align(r.base); // R9
          next_r.state = CBC_ISSUE;
          next_r.busy = 1'b1; // R4
        end
      end
      CBC_ISSUE: begin
        // One request per line; its fields stand until the next request
        next_r.req_valid = 1'b1; // R1
        next_r.req_l2 = op_is_l2(r.op);
        next_r.req_wb = op_does_wb(r.op);
        next_r.req_inv = op_does_inv(r.op);
        next_r.req_addr = r.line_addr;
        next_r.state = CBC_WAIT;
      end
      CBC_WAIT: begin
        // A partial last line still costs a whole request
        if (cache_ack) begin
          next_r.count = cbc_words_left(r.count); // R9
          next_r.line_addr = r.line_addr + LINE_BYTES;
          if (last_line(r.count)) begin
            next_r.state = CBC_DONE;
          end else begin
            next_r.state = CBC_ISSUE;
          end
        end
      end
      CBC_DONE: begin
        next_r.busy = 1'b0; // R4
        next_r.state = CBC_IDLE;
      end
      default: begin
        next_r.state = CBC_IDLE;
        next_r.busy = 1'b0;
      end
    endcase

    // A fence holds the core while this engine or other memory work is outstanding
    next_r.fence_stall = memory_fence_instr && (next_r.busy || mem_pending); // R5
    // Hold off new allocations into the level-2 sets while the engine owns them
    next_r.set_guard = next_r.busy; // R8
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Every output is read straight from the state register

  assign range_word_count_reg = r.count; // R4
  assign busy = r.busy;
  assign fence_stall = r.fence_stall;
  assign req_valid = r.req_valid;
  assign req_l2 = r.req_l2;
  assign req_wb = r.req_wb;
  assign req_inv = r.req_inv;
  assign req_addr = r.req_addr;
  assign set_guard = r.set_guard;
endmodule : cbc_engine
`default_nettype wire

/* tb/cbc_engine_properties.sv */
// Concurrent checks on the ports of the coherence engine
`default_nettype none
module cbc_engine_chk
  import cbc_pkg::*;
(
  input wire logic            clk,
  input wire logic            sys_rst,
  input wire logic            range_word_count_reg_wr,
  input wire logic            memory_fence_instr,
  input wire logic            cache_ack,
  input wire logic [WC_W-1:0] range_word_count_reg,
  input wire logic            busy,
  input wire logic            fence_stall,
  input wire logic            req_valid,
  input wire logic            req_wb,
  input wire logic            req_inv,
  input wire logic            set_guard
);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_start; $rose(busy); endsequence
  a_start_by_write: assert property (s_start |-> $past(range_word_count_reg_wr) ##1 req_valid)
    else $error("start without count write");
  a_count_done: assert property (busy && range_word_count_reg == '0 |=> !busy)
    else $error("busy with zero count");
  a_count_drop: assert property (cache_ack && range_word_count_reg > 16'h0010 |=>
    range_word_count_reg == $past(range_word_count_reg) - 16'h0010)
    else $error("count did not drop");
  a_fence_stall: assert property (memory_fence_instr && busy && range_word_count_reg != '0
    |=> fence_stall)
    else $error("fence not stalled");
  a_guard_set: assert property (set_guard == busy)
    else $error("guard differs from busy");
  a_req_action: assert property (req_valid |-> req_wb || req_inv)
    else $error("request without action");
endmodule : cbc_engine_chk
bind cbc_engine cbc_engine_chk chk (.clk, .sys_rst, .range_word_count_reg_wr,
  .memory_fence_instr, .cache_ack, .range_word_count_reg, .busy, .fence_stall,
  .req_valid, .req_wb, .req_inv, .set_guard);
`default_nettype wire

/* tb/cbc_cache_model.sv */
// Cache side that answers each line request after a chosen delay
`default_nettype none
module cbc_cache_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       req_valid,
  input  wire logic [1:0] lat,
  output logic            cache_ack
);
  timeunit 1ns; timeprecision 1ns;
  logic [3:0] cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
      cache_ack <= 1'b0;
    end else begin
      cache_ack <= cnt == 4'h1;
      cnt <= req_valid ? 4'(lat) + 4'h1 : (cnt != 4'h0 ? cnt - 4'h1 : cnt);
    end
  end
endmodule : cbc_cache_model
`default_nettype wire

/* tb/cbc_engine_test.sv */
// Self-checking bench of the coherence engine
`default_nettype none
module cbc_engine_test
  import cbc_pkg::*;
;
  timeunit 1ns; timeprecision 1ns;
  logic clk = 0, sys_rst = 1, bw = 0, ww = 0, fence = 0, pend = 0;
  logic ack, busy, stall, rv, l2, wb, inv, sg;
  logic [2:0] bop = 0, wop = 0;
  logic [31:0] bdat = 0, ra;
  logic [15:0] wdat = 0, cnt;
  logic [1:0] lat = 0;
  int bad_count = 0, n_checks = 0, nreq;
  always #25 clk = ~clk;
  always @(posedge clk) if (rv) nreq++;
  cbc_engine dut (.clk, .sys_rst, .base_wr(bw), .base_op(bop), .base_data(bdat),
    .range_word_count_reg_wr(ww), .range_word_count_reg_op(wop), .range_word_count_reg_data(wdat),
    .memory_fence_instr(fence), .mem_pending(pend), .cache_ack(ack), .range_word_count_reg(cnt),
    .busy, .fence_stall(stall), .req_valid(rv), .req_l2(l2), .req_wb(wb), .req_inv(inv),
    .req_addr(ra), .set_guard(sg));
  cbc_cache_model cache (.clk, .sys_rst, .req_valid(rv), .lat, .cache_ack(ack));
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task run(input logic [2:0] op, input logic [15:0] n);
    @(posedge clk) #5 bw = 1; bop = op; bdat = 32'h0000_1000;
    @(posedge clk) #5 bw = 0; ww = 1; wop = op; wdat = n;
    @(posedge clk) #5 ww = 0; nreq = 0;
    chk(busy, n != 0);
    chk(cnt, n);
    chk(stall, fence && n != 0);
    chk(sg, n != 0);
    @(posedge clk) #5;
    chk(rv, n != 0);
    if (n != 0) chk(ra, 32'h0000_1000);
    for (int i = 0; i < 200 && cnt !== 16'h0000; i++) @(posedge clk) #5;
    chk(cnt, 0);
    if (n != 0) chk({l2, wb, inv}, {op[2], op[0], op[1]});
    repeat (16) @(posedge clk);
    #5;
    chk(nreq, (n + 15) / 16);
    chk(busy, 0);
    chk(sg, 0);
    chk(stall, fence && pend);
  endtask : run
  task refused(input logic [2:0] bo, input logic [2:0] wo);
    @(posedge clk) #5 bw = 1; bop = bo; bdat = 32'h0000_2000;
    @(posedge clk) #5 bw = 0; ww = 1; wop = wo; wdat = 16'h0020;
    @(posedge clk) #5 ww = 0; nreq = 0;
    repeat (4) @(posedge clk);
    #5;
    chk(busy, 0);
    chk(cnt, 0);
    chk(nreq, 0);
  endtask : refused
  initial begin
    repeat (10) @(posedge clk);
    #5 sys_rst = 0;
    for (int k = 1; k < 8; k++) if (k != 4) run(3'(k), 16'h0020);
    run(OP_L1_WB, 16'h0000);
    refused(3'h4, 3'h4);
    refused(OP_L1_WB, OP_L2_WB);
    lat = 3;
    fence = 1;
    run(OP_L2_WBINV, 16'h0011);
    pend = 1;
    @(posedge clk) #5 chk(stall, 1);
    results();
  end
  initial begin
    #100000;
    bad_count++;
    results();
  end
endmodule : cbc_engine_test
`default_nettype wire
